//--- ctm_defs.svh
// Constants of the compact timer: register offsets, field positions, codes.
// Assumes nothing; included by the package and by every design file.
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH

// Register byte offsets on the APB bus
`define CTM_OFS_CTRL0     8'h00
`define CTM_OFS_CTRL1     8'h04
`define CTM_OFS_CNT_LO    8'h08
`define CTM_OFS_CNT_HI    8'h0C
`define CTM_OFS_CMPA_LO   8'h10
`define CTM_OFS_CMPA_HI   8'h14
`define CTM_OFS_PERIOD    8'h18
`define CTM_OFS_STATUS    8'h1C

// First control register fields
`define CTM_C0_PAUSE      7
`define CTM_C0_CKSEL_HI   6
`define CTM_C0_CKSEL_LO   4
`define CTM_C0_ON         3
`define CTM_C0_WMASK      8'hF8

// Second control register fields
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_ACT_HI     5
`define CTM_C1_ACT_LO     4
`define CTM_C1_INIT       3
`define CTM_C1_INV        2
`define CTM_C1_SWAP       1
`define CTM_C1_CLRSRC     0

// Status register fields
`define CTM_ST_AFLAG      0
`define CTM_ST_PFLAG      1

// Reset values
`define CTM_RST_BYTE      8'h00
`define CTM_RST_WORD      16'h0000

// Operating mode codes
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_UNDEF    2'h1
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3

// Pin action codes
`define CTM_ACT_00        2'h0
`define CTM_ACT_01        2'h1
`define CTM_ACT_10        2'h2
`define CTM_ACT_11        2'h3

// Clock source codes
`define CTM_CK_SYS4       3'h0
`define CTM_CK_SYS        3'h1
`define CTM_CK_H16        3'h2
`define CTM_CK_H64        3'h3
`define CTM_CK_SUB0       3'h4
`define CTM_CK_SUB1       3'h5
`define CTM_CK_EXT_RISE   3'h6
`define CTM_CK_EXT_FALL   3'h7

// Prescaler terminal values
`define CTM_PRE_DIV4      6'h03
`define CTM_PRE_DIV16     6'h0F
`define CTM_PRE_DIV64     6'h3F

`endif

//--- ctm_pkg.sv
// Types shared by the compact timer design files.
// Assumes the constants header is on the include path.
`default_nettype none
`include "ctm_defs.svh"

package ctm_pkg;
	typedef logic [15:0] ctm_count_t;
	typedef logic [7:0]  ctm_byte_t;
	typedef logic [2:0]  ctm_cksel_t;
	typedef logic [1:0]  ctm_code_t;
endpackage : ctm_pkg

`default_nettype wire

//--- ctm_tick_gen.sv
// Count tick generator: picks one of seven clock sources (two codes share sub_tick) and emits a pulse.
// Assumes fH equals pclk, sub_tick is a one-cycle pulse, inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.svh"

module ctm_tick_gen (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Source choice and raw sources
	input  wire ctm_pkg::ctm_cksel_t clock_source_select,
	input  wire logic               sub_tick,
	input  wire logic               external_count_input,
	// Count tick
	output logic                    tick
);
	logic [5:0] pre_r;
	logic       ext_q_r;

	// Free running prescaler shared by the divided sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 6'h00;
		end else begin
			pre_r <= pre_r + 6'h01;
		end
	end

	// Previous pin level for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q_r <= 1'b0;
		end else begin
			ext_q_r <= external_count_input;
		end
	end

	// Source multiplexer
	always_comb begin
		case (clock_source_select)
			`CTM_CK_SYS4:     tick = (pre_r[1:0] == 2'(`CTM_PRE_DIV4));
			`CTM_CK_SYS:      tick = 1'b1;
			`CTM_CK_H16:      tick = (pre_r[3:0] == 4'(`CTM_PRE_DIV16));
			`CTM_CK_H64:      tick = (pre_r == `CTM_PRE_DIV64);
			`CTM_CK_SUB0,
			`CTM_CK_SUB1:     tick = sub_tick;
			`CTM_CK_EXT_RISE: tick = external_count_input & ~ext_q_r;
			`CTM_CK_EXT_FALL: tick = ~external_count_input & ext_q_r;
			default:          tick = 1'b0;
		endcase
	end
endmodule : ctm_tick_gen

`default_nettype wire

//--- ctm_out_ctl.sv
// Output pin control for compare match and PWM modes.
// Assumes start and a_match are one-cycle pulses from the counter logic.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.svh"

module ctm_out_ctl (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Configuration
	input  wire ctm_pkg::ctm_code_t op_mode_select,
	input  wire ctm_pkg::ctm_code_t pin_action_select,
	input  wire logic               output_initial_level,
	input  wire logic               output_invert,
	// Events
	input  wire logic               start,
	input  wire logic               a_match,
	input  wire logic               pwm_active,
	// Pin
	output logic                    timer_output_pin,
	output logic                    timer_output_en
);
	logic cmp_level_r;
	logic cmp_level_nxt;
	logic raw;

	// Compare mode level: restart loads the initial level, A match acts
	always_comb begin
		cmp_level_nxt = cmp_level_r;
		if (start) begin
			cmp_level_nxt = output_initial_level;
		end else if (a_match) begin
			case (pin_action_select)
				`CTM_ACT_01: cmp_level_nxt = 1'b0;
				`CTM_ACT_10: cmp_level_nxt = 1'b1;
				`CTM_ACT_11: cmp_level_nxt = ~cmp_level_r;
				default:     cmp_level_nxt = cmp_level_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_level_r <= 1'b0;
		end else begin
			cmp_level_r <= cmp_level_nxt;
		end
	end

	// Level before inversion; active level in PWM is the initial level bit
	always_comb begin
		case (op_mode_select)
			`CTM_MODE_CMP: raw = cmp_level_nxt;
			`CTM_MODE_PWM: begin
				case (pin_action_select)
					`CTM_ACT_01: raw = output_initial_level;
					`CTM_ACT_10: raw = pwm_active ? output_initial_level
						: ~output_initial_level;
					default:     raw = ~output_initial_level;
				endcase
			end
			default:       raw = 1'b0;
		endcase
	end

	// Registered pin; timer/counter mode leaves the pin undriven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
			timer_output_en  <= 1'b0;
		end else begin
			timer_output_pin <= raw ^ output_invert;
			timer_output_en  <= (op_mode_select == `CTM_MODE_CMP)
				| (op_mode_select == `CTM_MODE_PWM);
		end
	end
endmodule : ctm_out_ctl

`default_nettype wire

//--- ctm_top.sv
// Compact 16-bit timer: APB registers, count-up counter, two comparators.
// Assumes a single 125 MHz pclk; pins and sub_tick are synchronous to it.
// Function
// - Pause bit holds counter, resume from value
// - Three-bit field selects counter clock source
// - Timer-on low stops; rising edge clears counter
// - Timer-on rise restores initial pin level in compare mode
// - Low three bits of control zero read zero
// - Mode field: compare, PWM, timer/counter
// - Timer/counter mode leaves pin undriven
// - Compare A match action: keep, low, high, toggle
// - PWM action: inactive, active, waveform
// - Initial level bit: start level or polarity
// - Invert bit inverts output pin
// - Swap bit exchanges PWM period and duty
// - Clear source: compare A or compare P
// - PWM ignores clear source, uses period comparator
// - Counter readable as two read-only bytes
// - Compare A sixteen bits, compare P eight
// - Low bytes pass through shared byte buffer
// - Compare P matches top eight counter bits
// - Match flags; P flag blocked by clear source
// - Sixteen-bit up counter, A compares all bits
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.svh"

module ctm_top (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	// APB answer
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Count sources
	input  wire logic        sub_tick,
	input  wire logic        external_count_input,
	// Output pin
	output logic             timer_output_pin,
	output logic             timer_output_en,
	// Match flags
	output logic             compare_a_flag,
	output logic             compare_p_flag
);
	// Register state
	ctm_pkg::ctm_byte_t  ctrl0_r;
	ctm_pkg::ctm_byte_t  ctrl1_r;
	ctm_pkg::ctm_count_t count_r;
	ctm_pkg::ctm_count_t cmp_a_r;
	ctm_pkg::ctm_byte_t  cmp_p_r;
	ctm_pkg::ctm_byte_t  buf_r;
	logic                on_q_r;

	// Bus helpers
	logic                access;
	logic                done;
	logic                wr_done;
	logic                rd_done;
	logic                mapped;
	logic [31:0]         rd_word;

	// Decoded fields
	logic                counter_pause;
	ctm_pkg::ctm_cksel_t clock_source_select;
	logic                timer_on;
	ctm_pkg::ctm_code_t  op_mode_select;
	ctm_pkg::ctm_code_t  pin_action_select;
	logic                output_initial_level;
	logic                output_invert;
	logic                duty_period_swap;
	logic                clear_source_select;

	// Counter helpers
	logic                tick;
	logic                start;
	logic                run;
	ctm_pkg::ctm_count_t inc;
	logic                a_match;
	logic                p_match;
	logic                clr;
	logic                is_pwm;
	logic [16:0]         duty;
	logic                pwm_active;

	// Address decode used for the mapping check; the read mux decodes paddr itself
	function automatic logic ctm_is_mapped(input logic [7:0] a);
		case (a)
			`CTM_OFS_CTRL0, `CTM_OFS_CTRL1, `CTM_OFS_CNT_LO, `CTM_OFS_CNT_HI,
			`CTM_OFS_CMPA_LO, `CTM_OFS_CMPA_HI, `CTM_OFS_PERIOD,
			`CTM_OFS_STATUS: ctm_is_mapped = 1'b1;
			default:         ctm_is_mapped = 1'b0;
		endcase
	endfunction : ctm_is_mapped

	// Field extraction
	assign counter_pause        = ctrl0_r[`CTM_C0_PAUSE];
	assign clock_source_select  = ctrl0_r[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
	assign timer_on             = ctrl0_r[`CTM_C0_ON];
	assign op_mode_select       = ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
	assign pin_action_select    = ctrl1_r[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
	assign output_initial_level = ctrl1_r[`CTM_C1_INIT];
	assign output_invert        = ctrl1_r[`CTM_C1_INV];
	assign duty_period_swap     = ctrl1_r[`CTM_C1_SWAP];
	assign clear_source_select  = ctrl1_r[`CTM_C1_CLRSRC];

	// APB handshake: one wait state so that every answer comes from a flop
	assign access  = psel & penable;
	assign done    = access & pready;
	assign wr_done = done & pwrite & mapped;
	assign rd_done = done & ~pwrite & mapped;
	assign mapped  = ctm_is_mapped(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
		end
	end

	// Read multiplexer; low bytes of pairs come from the shared buffer
	always_comb begin
		rd_word = 32'h00000000;
		case (paddr)
			`CTM_OFS_CTRL0:   rd_word[7:0] = ctrl0_r & `CTM_C0_WMASK;
			`CTM_OFS_CTRL1:   rd_word[7:0] = ctrl1_r;
			`CTM_OFS_CNT_LO:  rd_word[7:0] = buf_r;
			`CTM_OFS_CNT_HI:  rd_word[7:0] = count_r[15:8];
			`CTM_OFS_CMPA_LO: rd_word[7:0] = buf_r;
			`CTM_OFS_CMPA_HI: rd_word[7:0] = cmp_a_r[15:8];
			`CTM_OFS_PERIOD:  rd_word[7:0] = cmp_p_r;
			`CTM_OFS_STATUS:  rd_word[1:0] = {compare_p_flag, compare_a_flag};
			default:          rd_word      = 32'h00000000;
		endcase
	end

	// Read data captured with the ready flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (access & ~pready & ~pwrite) begin
			prdata <= rd_word;
		end
	end

	// Control registers; unimplemented bits are never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r <= `CTM_RST_BYTE;
			ctrl1_r <= `CTM_RST_BYTE;
		end else if (wr_done) begin
			if (paddr == `CTM_OFS_CTRL0) begin
				ctrl0_r <= pwdata[7:0] & `CTM_C0_WMASK;
			end
			if (paddr == `CTM_OFS_CTRL1) begin
				ctrl1_r <= pwdata[7:0];
			end
		end
	end

	// Compare registers: A high write commits the buffered low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_a_r <= `CTM_RST_WORD;
			cmp_p_r <= `CTM_RST_BYTE;
		end else if (wr_done) begin
			if (paddr == `CTM_OFS_CMPA_HI) begin
				cmp_a_r <= {pwdata[7:0], buf_r};
			end
			if (paddr == `CTM_OFS_PERIOD) begin
				cmp_p_r <= pwdata[7:0];
			end
		end
	end

	// Shared byte buffer: A low writes fill it, high reads latch low bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_r <= `CTM_RST_BYTE;
		end else if (wr_done && paddr == `CTM_OFS_CMPA_LO) begin
			buf_r <= pwdata[7:0];
		end else if (rd_done && paddr == `CTM_OFS_CNT_HI) begin
			buf_r <= count_r[7:0];
		end else if (rd_done && paddr == `CTM_OFS_CMPA_HI) begin
			buf_r <= cmp_a_r[7:0];
		end
	end

	// Clock source selection
	ctm_tick_gen u_tick (
		.pclk                 (pclk),
		.presetn              (presetn),
		.clock_source_select  (clock_source_select),
		.sub_tick             (sub_tick),
		.external_count_input (external_count_input),
		.tick                 (tick)
	);

	// Previous timer-on level, to find its rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q_r <= 1'b0;
		end else begin
			on_q_r <= timer_on;
		end
	end

	assign start  = timer_on & ~on_q_r;
	assign run    = tick & timer_on & ~counter_pause & ~start;
	assign inc    = count_r + 16'h0001;
	assign is_pwm = (op_mode_select == `CTM_MODE_PWM);

	// Comparators look at the value the counter is about to take.
	// A value of zero in A would match only on wrap, so it never flags.
	assign a_match = run & (inc == cmp_a_r) & (cmp_a_r != `CTM_RST_WORD);
	// P sees only the top byte; zero in P matches at wrap, i.e. 65536 ticks
	assign p_match = run & (inc[7:0] == 8'h00) & (inc[15:8] == cmp_p_r);

	// Clear choice: PWM follows the period comparator, else clear source
	always_comb begin
		if (is_pwm) begin
			clr = duty_period_swap ? a_match : p_match;
		end else begin
			clr = clear_source_select ? a_match : p_match;
		end
	end

	// Counter: restart, pause hold, clear on match, else count up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= `CTM_RST_WORD;
		end else if (start) begin
			count_r <= `CTM_RST_WORD;
		end else if (run) begin
			count_r <= clr ? `CTM_RST_WORD : inc;
		end
	end

	// Duty threshold; a P value of zero stands for 65536
	always_comb begin
		if (duty_period_swap) begin
			duty = (cmp_p_r == 8'h00) ? 17'h10000 : {1'b0, cmp_p_r, 8'h00};
		end else begin
			duty = {1'b0, cmp_a_r};
		end
	end

	// Active while below duty; duty at or over the period keeps it on
	assign pwm_active = ({1'b0, count_r} < duty);

	// Match flags, write one to clear; a new match wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_a_flag <= 1'b0;
			compare_p_flag <= 1'b0;
		end else begin
			if (a_match) begin
				compare_a_flag <= 1'b1;
			end else if (wr_done && paddr == `CTM_OFS_STATUS
				&& pwdata[`CTM_ST_AFLAG]) begin
				compare_a_flag <= 1'b0;
			end
			if (p_match & ~clear_source_select) begin
				compare_p_flag <= 1'b1;
			end else if (wr_done && paddr == `CTM_OFS_STATUS
				&& pwdata[`CTM_ST_PFLAG]) begin
				compare_p_flag <= 1'b0;
			end
		end
	end

	// Output pin logic
	ctm_out_ctl u_out (
		.pclk                 (pclk),
		.presetn              (presetn),
		.op_mode_select       (op_mode_select),
		.pin_action_select    (pin_action_select),
		.output_initial_level (output_initial_level),
		.output_invert        (output_invert),
		.start                (start),
		.a_match              (a_match),
		.pwm_active           (pwm_active),
		.timer_output_pin     (timer_output_pin),
		.timer_output_en      (timer_output_en)
	);
endmodule : ctm_top

`default_nettype wire

//--- ctm_ext_src.sv
// Far-side model: sub clock ticks and an external count pulse train.
// Assumes one pclk; all outputs change just after its rising edge.
`timescale 1ns/1ps
`default_nettype none

module ctm_ext_src #(
	parameter int SUB_DIV = 16
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Pulse request
	input  wire logic       ext_go,
	input  wire logic [7:0] ext_n,
	output logic            ext_busy,
	// Count sources
	output logic            sub_tick,
	output logic            external_count_input
);
	logic [7:0] sub_cnt_r;
	logic [9:0] ph_r;

	// Sub clock: one-cycle pulse every SUB_DIV cycles, never two adjacent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_cnt_r <= 8'h00;
			sub_tick  <= 1'b0;
		end else begin
			sub_cnt_r <= (sub_cnt_r == 8'(SUB_DIV - 1)) ? 8'h00 : sub_cnt_r + 8'h01;
			sub_tick  <= (sub_cnt_r == 8'(SUB_DIV - 1));
		end
	end

	// Pulse train, two high and two low, slow enough for the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph_r <= 10'h000;
		else if (ext_go)
			ph_r <= {ext_n, 2'h0};
		else if (ph_r != 10'h000)
			ph_r <= ph_r - 10'h001;
	end
	assign external_count_input = ph_r[1]; // Idle low, as with a pull-down
	assign ext_busy             = (ph_r != 10'h000);
endmodule : ctm_ext_src
`default_nettype wire

//--- ctm_top_sva.sv
// Checker for the compact timer: APB timing and output pin behaviour.
// Assumes it is bound to ctm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.svh"

module ctm_top_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and flags
	input wire logic        sub_tick,
	input wire logic        external_count_input,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_en,
	input wire logic        compare_a_flag,
	input wire logic        compare_p_flag
);
	logic [7:0] c0_r;
	logic [7:0] c1_r;
	logic [1:0] stab_r;
	logic       wr_ok;
	logic       wr_ctl;

	assign wr_ok  = psel && penable && pready && pwrite && !pslverr;
	assign wr_ctl = wr_ok && (paddr == `CTM_OFS_CTRL0 || paddr == `CTM_OFS_CTRL1);

	// Shadow of the control registers as the design took the writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c0_r <= 8'h00;
			c1_r <= 8'h00;
		end else if (wr_ok && paddr == `CTM_OFS_CTRL0) begin
			c0_r <= pwdata[7:0];
		end else if (wr_ok && paddr == `CTM_OFS_CTRL1) begin
			c1_r <= pwdata[7:0];
		end
	end

	// Cycles since a control write, so registered pins get time to settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stab_r <= 2'h0;
		else if (wr_ctl)
			stab_r <= 2'h0;
		else if (stab_r != 2'h3)
			stab_r <= stab_r + 2'h1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_apb_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not in the second access cycle");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_ctrl_low_zero: assert property (pready && !pwrite && paddr == `CTM_OFS_CTRL0 |-> prdata[2:0] == 3'h0)
		else $error("control low bits not zero");
	chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_tmr_pin_off: assert property (stab_r == 2'h3 && c1_r[6] |-> !timer_output_en)
		else $error("pin driven in timer/counter mode");
	chk_pin_drive_on: assert property (stab_r == 2'h3 && !c1_r[6] |-> timer_output_en)
		else $error("pin not driven in compare or PWM mode");
	chk_p_flag_block: assert property (c1_r[0] && $past(c1_r[0]) |-> !$rose(compare_p_flag))
		else $error("P flag raised with clear source A");
	chk_start_level: assert property (wr_ok && paddr == `CTM_OFS_CTRL0 && pwdata[3] && !c0_r[3]
		&& c1_r[7:6] == 2'h0 |-> ##[1:2] timer_output_pin == (c1_r[3] ^ c1_r[2]))
		else $error("pin not at initial level after start");
	chk_pwm_forced: assert property (stab_r == 2'h3 && c0_r[3] && c1_r[7:6] == 2'h2 && !c1_r[5]
		|-> timer_output_pin == (c1_r[3] ^ c1_r[2] ^ !c1_r[4]))
		else $error("forced PWM level wrong");
endmodule : ctm_top_chk

bind ctm_top ctm_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sub_tick(sub_tick),
	.external_count_input(external_count_input), .timer_output_pin(timer_output_pin),
	.timer_output_en(timer_output_en), .compare_a_flag(compare_a_flag),
	.compare_p_flag(compare_p_flag));
`default_nettype wire

//--- compact_timer_module_bench.sv
// Self-checking bench for the compact timer through its APB registers.
// Assumes ctm_top, the source model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module compact_timer_module_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_go = 1'b0;
	logic [7:0]  paddr = 8'h00, ext_n = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, sub_tick, ext_in, pin, pin_en, fa, fp, ext_busy, err;
	logic [15:0] cnt;
	int          bad_count = 0, samples_checked = 0;
	int          dv[6] = '{4, 1, 16, 64, 32, 32};

	always #4 pclk = ~pclk;

	ctm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sub_tick(sub_tick), .external_count_input(ext_in),
		.timer_output_pin(pin), .timer_output_en(pin_en), .compare_a_flag(fa),
		.compare_p_flag(fp));
	ctm_ext_src #(.SUB_DIV(32)) u_src (.pclk(pclk), .presetn(presetn), .ext_go(ext_go),
		.ext_n(ext_n), .ext_busy(ext_busy), .sub_tick(sub_tick),
		.external_count_input(ext_in));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// One APB transfer; request held until pready is seen, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		`CHK("pready", 1'b1, pready)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, {24'h0, e}, rd)
	endtask : rchk

	// High byte first: it latches the low byte into the shared buffer
	task automatic rcnt();
		apb(1'b0, `CTM_OFS_CNT_HI, 32'h0);
		cnt[15:8] = rd[7:0];
		apb(1'b0, `CTM_OFS_CNT_LO, 32'h0);
		cnt[7:0] = rd[7:0];
	endtask : rcnt

	// Waits for the source model with a bound, then lets the pin settle
	task automatic pulse(input logic [7:0] n);
		int k;
		k = 0;
		ext_n <= n;
		ext_go <= 1'b1;
		@(posedge pclk);
		ext_go <= 1'b0;
		@(posedge pclk);
		while (ext_busy !== 1'b0 && k < 1200) begin
			@(posedge pclk);
			k++;
		end
		`CHK("pulse done", 1'b0, ext_busy)
		cyc(6);
	endtask : pulse

	// Main sequence
	initial begin
		logic [15:0] c;
		logic [1:0]  act;
		logic        inv;
		int          e, hi, n;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		cyc(2);
		for (int i = 0; i < 7; i++) rchk(8'(4 * i), 8'h00, "reset value");
		apb(1'b1, `CTM_OFS_CNT_HI, 32'hFF);
		rchk(`CTM_OFS_CNT_HI, 8'h00, "count read only");
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, `CTM_OFS_CTRL0, 32'h87);
		rchk(`CTM_OFS_CTRL0, 8'h80, "ctrl0 low bits");
		apb(1'b1, `CTM_OFS_CMPA_LO, 32'h34);
		apb(1'b1, `CTM_OFS_CMPA_HI, 32'h12);
		apb(1'b1, `CTM_OFS_CMPA_LO, 32'h56);
		rchk(`CTM_OFS_CMPA_HI, 8'h12, "A high");
		rchk(`CTM_OFS_CMPA_LO, 8'h34, "A low");
		apb(1'b1, `CTM_OFS_PERIOD, 32'h5A);
		rchk(`CTM_OFS_PERIOD, 8'h5A, "P value");
		// Pause holds, resume counts on, off keeps the residue, restart clears
		apb(1'b1, `CTM_OFS_CTRL1, 32'hC0);
		apb(1'b1, `CTM_OFS_CTRL0, 32'h18);
		cyc(40);
		apb(1'b1, `CTM_OFS_CTRL0, 32'h98);
		rcnt();
		c = cnt;
		cyc(20);
		rcnt();
		`CHK("paused count", c, cnt)
		apb(1'b1, `CTM_OFS_CTRL0, 32'h18);
		cyc(20);
		apb(1'b1, `CTM_OFS_CTRL0, 32'h10);
		rcnt();
		`CHK("resumed", 1'b1, cnt > c)
		c = cnt;
		cyc(20);
		rcnt();
		`CHK("off holds", c, cnt)
		apb(1'b1, `CTM_OFS_CTRL0, 32'h98);
		rcnt();
		`CHK("restart zero", 16'h0000, cnt)
		// Internal sources counted over a window of about 512 cycles
		foreach (dv[i]) begin
			apb(1'b1, `CTM_OFS_CTRL0, 32'h0);
			apb(1'b1, `CTM_OFS_CTRL0, {24'h0, 1'b0, 3'(i), 4'h8});
			cyc(508);
			apb(1'b1, `CTM_OFS_CTRL0, {24'h0, 1'b1, 3'(i), 4'h8});
			rcnt();
			`CHK("source rate", 1'b1, cnt inside {[512 / dv[i] - 2 : 512 / dv[i] + 2]})
		end
		// Compare mode on pin edges: every action, level and polarity
		apb(1'b1, `CTM_OFS_CMPA_LO, 32'h04);
		apb(1'b1, `CTM_OFS_CMPA_HI, 32'h00);
		for (int k = 0; k < 16; k++) begin
			apb(1'b1, `CTM_OFS_CTRL0, {24'h0, 3'h3, k[2], 4'h0});
			apb(1'b1, `CTM_OFS_CTRL1, {24'h0, 2'h0, k[3:0], 2'h1});
			apb(1'b1, `CTM_OFS_STATUS, 32'h3);
			apb(1'b1, `CTM_OFS_CTRL0, {24'h0, 3'h3, k[2], 4'h8});
			cyc(3);
			`CHK("start level", k[1] ^ k[0], pin)
			`CHK("pin enabled", 1'b1, pin_en)
			pulse(8'h03);
			rcnt();
			`CHK("edge count", 16'h0003, cnt)
			pulse(8'h01);
			e = (k[3:2] == 2'h0) ? k[1] : ((k[3:2] == 2'h3) ? !k[1] : k[3]);
			`CHK("match level", 1'(e) ^ k[0], pin)
			`CHK("A flag", 1'b1, fa)
			`CHK("P flag blocked", 1'b0, fp)
			rcnt();
			`CHK("A clear", 16'h0000, cnt)
		end
		// Timer/counter mode: P of one gives a 256-tick period
		apb(1'b1, `CTM_OFS_CTRL0, 32'h10);
		apb(1'b1, `CTM_OFS_PERIOD, 32'h01);
		apb(1'b1, `CTM_OFS_CTRL1, 32'hC0);
		apb(1'b1, `CTM_OFS_STATUS, 32'h3);
		apb(1'b1, `CTM_OFS_CTRL0, 32'h18);
		n = 0;
		while (fp !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		`CHK("P period", 1'b1, n inside {[250:260]})
		`CHK("A flag tc", 1'b1, fa)
		`CHK("pin released", 1'b0, pin_en)
		// PWM, active high: forced levels, waveform, inversion, then swapped roles
		apb(1'b1, `CTM_OFS_CMPA_LO, 32'h40);
		apb(1'b1, `CTM_OFS_CMPA_HI, 32'h00);
		for (int k = 0; k < 7; k++) begin
			act = (k == 6) ? 2'h2 : 2'(k / 2);
			inv = (k == 6) ? 1'b0 : k[0];
			apb(1'b1, `CTM_OFS_CTRL0, 32'h10);
			if (k == 6) begin
				apb(1'b1, `CTM_OFS_CMPA_LO, 32'h00);
				apb(1'b1, `CTM_OFS_CMPA_HI, 32'h04);
			end
			apb(1'b1, `CTM_OFS_CTRL1, {24'h0, 2'h2, act, 1'b1, inv, k == 6, 1'b1});
			apb(1'b1, `CTM_OFS_STATUS, 32'h3);
			apb(1'b1, `CTM_OFS_CTRL0, 32'h18);
			cyc(8);
			hi = 0;
			repeat (1024) begin
				@(posedge pclk);
				hi += int'(pin === 1'b1);
			end
			e = (act == 2'h0) ? 0 : ((act == 2'h1) ? 1024 : 256);
			e = inv ? 1024 - e : e;
			`CHK("PWM high time", 1'b1, hi inside {[e - 4 : e + 4]})
			`CHK("P flag PWM", 1'b0, fp)
		end
		give_verdict();
	end

	// Watchdog, well beyond the roughly 12000 cycles the tests need
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		give_verdict();
	end
endmodule : compact_timer_module_bench
`default_nettype wire
